// file: src/uart_status_pkg.sv
// constants for the serial status, check-bit and timing block
package uart_status_pkg;
  // check_bit_kind field encodings
  localparam logic [2:0] CHK_EVEN      = 3'h0;
  localparam logic [2:0] CHK_ODD       = 3'h1;
  localparam logic [2:0] CHK_SPACE     = 3'h2;
  localparam logic [2:0] CHK_MARK      = 3'h3;
  localparam logic [2:0] CHK_NONE      = 3'h4;
  localparam logic [2:0] CHK_MULTI_A   = 3'h6;
  localparam logic [2:0] CHK_MULTI_B   = 3'h7;
  localparam int         CHK_W         = 3;
  localparam int         DATA_W        = 9;
  localparam int         GAP_W         = 8;
  localparam int         IDLE_W        = 16;
  localparam int         FLAG_W        = 5;
  // flag vector positions for the interrupt enables
  localparam int         FLG_RXAVAIL   = 0;
  localparam int         FLG_OVERWRITE = 1;
  localparam int         FLG_CHKERR    = 2;
  localparam int         FLG_TXFREE    = 3;
  localparam int         FLG_IDLE      = 4;
  localparam logic [DATA_W-1:0] RHR_RESET = 9'h000;
  localparam logic [GAP_W-1:0]  GAP_ZERO  = 8'h00;
  localparam logic [IDLE_W-1:0] IDLE_ZERO = 16'h0000;
endpackage

// file: src/uart_check_bit.sv
// check-bit generator and checker for one character
`timescale 1ns/1ps
`default_nettype none
module uart_check_bit
  import uart_status_pkg::*;
(
  input  wire logic [CHK_W-1:0]  kind,
  input  wire logic [DATA_W-1:0] data,
  input  wire logic              addr_mark,
  input  wire logic              rx_bit,
  output logic                   tx_bit,
  output logic                   tx_has_bit,
  output logic                   rx_error
);
  logic ones_odd;
  assign ones_odd = ^data;

  always_comb begin
    tx_bit     = 1'b0;
    tx_has_bit = 1'b1;
    rx_error   = 1'b0;
    case (kind)
      CHK_EVEN: begin
        tx_bit   = ones_odd;
        rx_error = rx_bit != ones_odd;
      end
      CHK_ODD: begin
        tx_bit   = ~ones_odd;
        rx_error = rx_bit != ~ones_odd;
      end
      CHK_MARK: begin
        tx_bit   = 1'b1;
        rx_error = ~rx_bit;
      end
      CHK_SPACE: begin
        tx_bit   = 1'b0;
        rx_error = rx_bit;
      end
      CHK_MULTI_A, CHK_MULTI_B: begin
        tx_bit   = addr_mark;
        rx_error = rx_bit;
      end
      default: begin
        tx_has_bit = 1'b0;
        rx_error   = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: src/uart_rx_status_parity_timing.sv
// character status, check bits, transmit gap and receive idle time-out
//
// What this block does
// - completed character stored, available flag set
// - completion while available sets overwrite, stores
// - clear-flags command clears overwrite error
// - five check-bit kinds plus multidrop selection
// - even check bit generated and checked
// - odd check bit generated and checked
// - mark sends one, zero received is error
// - space sends zero, one received is error
// - none sends no bit, never errors
// - check-bit error sticky until clear-flags
// - kinds six and seven select multidrop
// - multidrop data bit zero, address one
// - multidrop high received bit flags error
// - address-send marks only next written byte
// - zero gap length inserts no gap
// - nonzero gap holds line high N bits
// - holding-free stays low through gap while a character waits
// - transmitter idle low until gap ends
// - zero idle limit disables idle time-out
// - idle counter loads, decrements per bit, reloads
// - counter reaching zero raises idle-expired
// - idle-wait freezes counter until next character
// - idle-rearm reloads and counts immediately
`timescale 1ns/1ps
`default_nettype none
module uart_rx_status_parity_timing
  import uart_status_pkg::*;
(
  input  wire logic                                SYS_CLK,
  input  wire logic                                NRST,
  input  wire logic                                BIT_TICK,
  input  wire logic                                RX_DONE,
  input  wire logic [uart_status_pkg::DATA_W-1:0]  RX_DATA,
  input  wire logic                                RX_CHK_BIT,
  input  wire logic                                RX_READ,
  input  wire logic [uart_status_pkg::CHK_W-1:0]   CHECK_BIT_KIND,
  input  wire logic [uart_status_pkg::GAP_W-1:0]   TX_GAP_LENGTH,
  input  wire logic [uart_status_pkg::IDLE_W-1:0]  RX_IDLE_LIMIT,
  input  wire logic                                CLEAR_FLAGS_CMD,
  input  wire logic                                ADDRESS_SEND_CMD,
  input  wire logic                                IDLE_WAIT_CMD,
  input  wire logic                                IDLE_REARM_CMD,
  input  wire logic [uart_status_pkg::FLAG_W-1:0]  IRQ_ENABLE,
  input  wire logic                                TX_WRITE,
  input  wire logic [uart_status_pkg::DATA_W-1:0]  TX_WRITE_DATA,
  input  wire logic                                TX_SHIFT_DONE,
  output logic                                     TX_START,
  output logic      [uart_status_pkg::DATA_W-1:0]  TX_DATA,
  output logic                                     TX_CHK_BIT,
  output logic                                     TX_CHK_EN,
  output logic                                     TX_LINE_HOLD,
  output logic      [uart_status_pkg::DATA_W-1:0]  RX_HOLDING_REG,
  output logic                                     RX_CHAR_AVAIL_FLAG,
  output logic                                     OVERWRITE_ERROR_FLAG,
  output logic                                     CHECK_BIT_ERROR_FLAG,
  output logic                                     TX_HOLDING_FREE_FLAG,
  output logic                                     TX_IDLE_FLAG,
  output logic                                     IDLE_EXPIRED_FLAG,
  output logic                                     IRQ
);
  import uart_status_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // check-bit units, one for the receive check and one for transmit generation
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] tx_hold;
  logic              tx_hold_addr;
  logic              rx_err_now;
  logic              rx_chk_unused;
  logic              tx_bit_now;
  logic              tx_has_now;
  logic              rx_unused_has;

  uart_check_bit u_rx_chk (
    .kind       (CHECK_BIT_KIND),
    .data       (RX_DATA),
    .addr_mark  (1'b0),
    .rx_bit     (RX_CHK_BIT),
    .tx_bit     (rx_chk_unused),
    .tx_has_bit (rx_unused_has),
    .rx_error   (rx_err_now)
  );

  uart_check_bit u_tx_chk (
    .kind       (CHECK_BIT_KIND),
    .data       (tx_hold),
    .addr_mark  (tx_hold_addr),
    .rx_bit     (1'b0),
    .tx_bit     (tx_bit_now),
    .tx_has_bit (tx_has_now),
    .rx_error   ()
  );

  // ----------------------------------------------------------------
  // receive status
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_HOLDING_REG <= RHR_RESET;
    end else if (RX_DONE) begin
      RX_HOLDING_REG <= RX_DATA;
    end
  end

  // a completion in the read cycle wins: the new character is unread
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_CHAR_AVAIL_FLAG <= 1'b0;
    end else if (RX_DONE) begin
      RX_CHAR_AVAIL_FLAG <= 1'b1;
    end else if (RX_READ) begin
      RX_CHAR_AVAIL_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      OVERWRITE_ERROR_FLAG <= 1'b0;
    end else if (RX_DONE && RX_CHAR_AVAIL_FLAG) begin
      OVERWRITE_ERROR_FLAG <= 1'b1;
    end else if (CLEAR_FLAGS_CMD) begin
      OVERWRITE_ERROR_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CHECK_BIT_ERROR_FLAG <= 1'b0;
    end else if (RX_DONE && rx_err_now) begin
      CHECK_BIT_ERROR_FLAG <= 1'b1;
    end else if (CLEAR_FLAGS_CMD) begin
      CHECK_BIT_ERROR_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit holding, address marking and gap
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_GAP   = 3'b100
  } tx_state_t;

  tx_state_t         tx_state;
  logic              hold_full;
  logic              addr_pending;
  logic [GAP_W-1:0]  gap_count;
  logic              launch;

  // a new character leaves only once shifter and gap are both done
  assign launch = hold_full && (tx_state == TX_IDLE);

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      addr_pending <= 1'b0;
    end else if (TX_WRITE && !hold_full) begin
      // an accepted write consumes the mark, even one issued in the same cycle
      addr_pending <= 1'b0;
    end else if (ADDRESS_SEND_CMD) begin
      addr_pending <= 1'b1;
    end
  end

  // writes into an occupied holding register are dropped
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_full    <= 1'b0;
      tx_hold      <= RHR_RESET;
      tx_hold_addr <= 1'b0;
    end else if (TX_WRITE && !hold_full) begin
      hold_full    <= 1'b1;
      tx_hold      <= TX_WRITE_DATA;
      tx_hold_addr <= addr_pending || ADDRESS_SEND_CMD;
    end else if (launch) begin
      hold_full    <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_state  <= TX_IDLE;
      gap_count <= GAP_ZERO;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (launch) begin
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (TX_SHIFT_DONE) begin
            if (TX_GAP_LENGTH == GAP_ZERO) begin
              tx_state <= TX_IDLE;
            end else begin
              tx_state  <= TX_GAP;
              gap_count <= TX_GAP_LENGTH;
            end
          end
        end
        TX_GAP: begin
          if (BIT_TICK) begin
            gap_count <= gap_count - 8'h01;
            if (gap_count == 8'h01) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_START     <= 1'b0;
      TX_DATA      <= RHR_RESET;
      TX_CHK_BIT   <= 1'b0;
      TX_CHK_EN    <= 1'b0;
    end else begin
      TX_START <= launch;
      if (launch) begin
        TX_DATA    <= tx_hold;
        TX_CHK_BIT <= tx_bit_now;
        TX_CHK_EN  <= tx_has_now;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_LINE_HOLD         <= 1'b0;
      TX_HOLDING_FREE_FLAG <= 1'b1;
      TX_IDLE_FLAG         <= 1'b1;
    end else begin
      TX_LINE_HOLD         <= (tx_state == TX_GAP);
      TX_HOLDING_FREE_FLAG <= (!hold_full || launch) && !TX_WRITE;
      TX_IDLE_FLAG         <= (tx_state == TX_IDLE) && !hold_full && !TX_WRITE;
    end
  end

  // ----------------------------------------------------------------
  // receive idle time-out
  // ----------------------------------------------------------------
  logic [IDLE_W-1:0] idle_count;
  logic              idle_run;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      idle_count <= IDLE_ZERO;
      idle_run   <= 1'b0;
    end else if (RX_IDLE_LIMIT == IDLE_ZERO) begin
      idle_run   <= 1'b0;
      idle_count <= IDLE_ZERO;
    end else if (IDLE_REARM_CMD) begin
      idle_count <= RX_IDLE_LIMIT;
      idle_run   <= 1'b1;
    end else if (RX_DONE) begin
      idle_count <= RX_IDLE_LIMIT;
      idle_run   <= 1'b1;
    end else if (IDLE_WAIT_CMD) begin
      idle_run   <= 1'b0;
    end else if (idle_run && BIT_TICK) begin
      idle_count <= idle_count - 16'h0001;
      if (idle_count == 16'h0001) begin
        idle_run <= 1'b0;
      end
    end
  end

  logic idle_hit;
  assign idle_hit = idle_run && BIT_TICK && (idle_count == 16'h0001)
                    && !RX_DONE && !IDLE_REARM_CMD && !IDLE_WAIT_CMD
                    && (RX_IDLE_LIMIT != IDLE_ZERO);

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IDLE_EXPIRED_FLAG <= 1'b0;
    end else if (RX_IDLE_LIMIT == IDLE_ZERO) begin
      IDLE_EXPIRED_FLAG <= 1'b0;
    end else if (idle_hit) begin
      IDLE_EXPIRED_FLAG <= 1'b1;
    end else if (IDLE_WAIT_CMD || IDLE_REARM_CMD) begin
      IDLE_EXPIRED_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] flags;
  assign flags[FLG_RXAVAIL]   = RX_CHAR_AVAIL_FLAG;
  assign flags[FLG_OVERWRITE] = OVERWRITE_ERROR_FLAG;
  assign flags[FLG_CHKERR]    = CHECK_BIT_ERROR_FLAG;
  assign flags[FLG_TXFREE]    = TX_HOLDING_FREE_FLAG;
  assign flags[FLG_IDLE]      = IDLE_EXPIRED_FLAG;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags & IRQ_ENABLE);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_overwrite;
    @(posedge SYS_CLK) disable iff (!rst_n)
      RX_DONE && RX_CHAR_AVAIL_FLAG |=> OVERWRITE_ERROR_FLAG && RX_HOLDING_REG == $past(RX_DATA);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite not flagged");

  property p_store;
    @(posedge SYS_CLK) disable iff (!rst_n)
      RX_DONE |=> RX_CHAR_AVAIL_FLAG;
  endproperty
  a_store: assert property (p_store) else $error("character not available");

  property p_clear;
    @(posedge SYS_CLK) disable iff (!rst_n)
      CLEAR_FLAGS_CMD && !RX_DONE |=> !OVERWRITE_ERROR_FLAG && !CHECK_BIT_ERROR_FLAG;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_chk_sticky;
    @(posedge SYS_CLK) disable iff (!rst_n)
      CHECK_BIT_ERROR_FLAG && !CLEAR_FLAGS_CMD |=> CHECK_BIT_ERROR_FLAG;
  endproperty
  a_chk_sticky: assert property (p_chk_sticky) else $error("check error lost");

  property p_multi_rx;
    @(posedge SYS_CLK) disable iff (!rst_n)
      RX_DONE && RX_CHK_BIT && CHECK_BIT_KIND[2:1] == 2'b11 |=> CHECK_BIT_ERROR_FLAG;
  endproperty
  a_multi_rx: assert property (p_multi_rx) else $error("address char not flagged");

  property p_none;
    @(posedge SYS_CLK) disable iff (!rst_n)
      TX_START && $past(CHECK_BIT_KIND) == CHK_NONE |-> !TX_CHK_EN;
  endproperty
  a_none: assert property (p_none) else $error("check bit sent when disabled");

  property p_gap_idle;
    @(posedge SYS_CLK) disable iff (!rst_n)
      TX_LINE_HOLD |-> !TX_IDLE_FLAG;
  endproperty
  a_gap_idle: assert property (p_gap_idle) else $error("idle during gap");

  sequence s_gap_wait;
    (tx_state == TX_GAP) && hold_full;
  endsequence
  property p_gap_free;
    @(posedge SYS_CLK) disable iff (!rst_n)
      s_gap_wait |=> !TX_HOLDING_FREE_FLAG;
  endproperty
  a_gap_free: assert property (p_gap_free) else $error("holding free during gap");

  property p_idle_off;
    @(posedge SYS_CLK) disable iff (!rst_n)
      RX_IDLE_LIMIT == IDLE_ZERO |=> !IDLE_EXPIRED_FLAG;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("time-out while disabled");

  property p_rearm;
    @(posedge SYS_CLK) disable iff (!rst_n)
      IDLE_REARM_CMD && RX_IDLE_LIMIT != IDLE_ZERO |=> idle_run && idle_count == $past(RX_IDLE_LIMIT);
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm did not reload");
endmodule
`default_nettype wire

// file: tb/serial_far_end.sv
// far-end model: bit tick source, character shifter and character receiver
`timescale 1ns/1ps
`default_nettype none
module serial_far_end
  import uart_status_pkg::*;
(
  input  wire logic                               clk,
  input  wire logic                               nrst,
  input  wire logic                               tx_start,
  input  wire logic                               rx_go,
  input  wire logic [uart_status_pkg::DATA_W-1:0] rx_word,
  input  wire logic                               rx_par,
  output logic                                    tick,
  output logic                                    shift_done,
  output logic                                    rx_done,
  output logic      [uart_status_pkg::DATA_W-1:0] rx_data,
  output logic                                    rx_chk
);
  logic [1:0] div;
  logic       busy;
  logic [3:0] bits;
  logic       pend;
  // a tick every fourth cycle keeps frames short; the real divider is far slower
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 2'h0;
      tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      tick <= (div == 2'h3);
    end
  end
  // eleven bit periods per frame, done pulse one cycle after the last tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      bits <= 4'h0;
      shift_done <= 1'b0;
    end else begin
      shift_done <= busy && tick && (bits == 4'ha);
      if (tx_start) begin
        busy <= 1'b1;
        bits <= 4'h0;
      end else if (busy && tick) begin
        bits <= bits + 4'h1;
        busy <= (bits != 4'ha);
      end
    end
  end
  // outside the completion cycle the data lines toggle, so stale values never look valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      rx_done <= 1'b0;
      rx_data <= 9'h000;
      rx_chk <= 1'b0;
    end else begin
      rx_done <= pend && tick;
      if (pend && tick) begin
        rx_data <= rx_word;
        rx_chk <= rx_par;
        pend <= 1'b0;
      end else begin
        rx_data <= ~rx_data;
        rx_chk <= ~rx_chk;
        if (rx_go) begin
          pend <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the status, check-bit and timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import uart_status_pkg::*;
;
  logic              sys_clk, nrst, bit_tick, rx_done, rx_chk_bit, rx_read, clr, addr_cmd, wait_cmd, rearm_cmd;
  logic              tx_write, tx_shift_done, tx_start, tx_chk, tx_chk_en, line_hold, avail, ovr, chk_err;
  logic              tx_free, tx_idle, idle_exp, irq, rx_go, rx_par;
  logic [DATA_W-1:0] rx_data, tx_wdata, tx_data, rhr, rx_word, d;
  logic [CHK_W-1:0]  kind;
  logic [GAP_W-1:0]  gap;
  logic [IDLE_W-1:0] idle_lim;
  logic [FLAG_W-1:0] irq_en;
  int                fails, comparisons, seed, held, n, g;

  uart_rx_status_parity_timing dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .BIT_TICK(bit_tick), .RX_DONE(rx_done), .RX_DATA(rx_data),
    .RX_CHK_BIT(rx_chk_bit), .RX_READ(rx_read), .CHECK_BIT_KIND(kind), .TX_GAP_LENGTH(gap),
    .RX_IDLE_LIMIT(idle_lim), .CLEAR_FLAGS_CMD(clr), .ADDRESS_SEND_CMD(addr_cmd), .IDLE_WAIT_CMD(wait_cmd),
    .IDLE_REARM_CMD(rearm_cmd), .IRQ_ENABLE(irq_en), .TX_WRITE(tx_write), .TX_WRITE_DATA(tx_wdata),
    .TX_SHIFT_DONE(tx_shift_done), .TX_START(tx_start), .TX_DATA(tx_data), .TX_CHK_BIT(tx_chk),
    .TX_CHK_EN(tx_chk_en), .TX_LINE_HOLD(line_hold), .RX_HOLDING_REG(rhr), .RX_CHAR_AVAIL_FLAG(avail),
    .OVERWRITE_ERROR_FLAG(ovr), .CHECK_BIT_ERROR_FLAG(chk_err), .TX_HOLDING_FREE_FLAG(tx_free),
    .TX_IDLE_FLAG(tx_idle), .IDLE_EXPIRED_FLAG(idle_exp), .IRQ(irq));
  serial_far_end far (
    .clk(sys_clk), .nrst(nrst), .tx_start(tx_start), .rx_go(rx_go), .rx_word(rx_word), .rx_par(rx_par),
    .tick(bit_tick), .shift_done(tx_shift_done), .rx_done(rx_done), .rx_data(rx_data), .rx_chk(rx_chk_bit));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic good_bit(input logic [CHK_W-1:0] k, input logic [DATA_W-1:0] v);
    case (k)
      CHK_EVEN: good_bit = ^v;
      CHK_ODD:  good_bit = ~^v;
      CHK_MARK: good_bit = 1'b1;
      default:  good_bit = 1'b0;
    endcase
  endfunction
  function automatic logic has_bit(input logic [CHK_W-1:0] k);
    has_bit = (k != CHK_NONE) && (k != 3'h5);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic give_up(input string name);
    fails++;
    $display("BAD %s expected response seen timeout", name);
    report_and_stop();
  endtask
  // commands: 0 clear flags, 1 address send, 2 idle wait, 3 idle rearm, 4 holding read
  task automatic pulse(input int which);
    case (which)
      0: clr = 1'b1;
      1: addr_cmd = 1'b1;
      2: wait_cmd = 1'b1;
      3: rearm_cmd = 1'b1;
      default: rx_read = 1'b1;
    endcase
    @(negedge sys_clk);
    {clr, addr_cmd, wait_cmd, rearm_cmd, rx_read} = 5'h00;
    @(negedge sys_clk);
  endtask
  // the word stays put until the far end has delivered it
  task automatic rx_char(input logic [DATA_W-1:0] w, input logic b);
    int c;
    c = 0;
    rx_word = w;
    rx_par = b;
    rx_go = 1'b1;
    @(negedge sys_clk);
    rx_go = 1'b0;
    while (rx_done !== 1'b1) begin
      if (++c > 20) give_up("rx_done");
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
  // an edge passes after lowering the strobe so back-to-back writes never collide
  task automatic tx_put(input logic [DATA_W-1:0] w);
    tx_wdata = w;
    tx_write = 1'b1;
    @(negedge sys_clk);
    tx_write = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic tx_send(input logic [DATA_W-1:0] w);
    int c;
    c = 0;
    tx_put(w);
    while (tx_start !== 1'b1) begin
      if (++c > 20) give_up("tx_start");
      @(negedge sys_clk);
    end
  endtask
  // runs until the transmitter is idle or the next character starts; counts gap ticks
  task automatic tx_finish(input logic waiting, output int hold_ticks);
    int c;
    c = 0;
    hold_ticks = 0;
    @(negedge sys_clk);
    while (tx_idle !== 1'b1 && tx_start !== 1'b1) begin
      if (line_hold === 1'b1 && bit_tick === 1'b1) hold_ticks++;
      if (line_hold === 1'b1 && waiting) check("free_in_gap", tx_free, 0);
      if (++c > 2000) give_up("tx_idle");
      @(negedge sys_clk);
    end
    check("hold_at_end", line_hold, 0);
  endtask
  task automatic ticks_to_expiry(output int t);
    int c;
    c = 0;
    t = 0;
    while (idle_exp !== 1'b1) begin
      @(negedge sys_clk);
      if (idle_exp !== 1'b1 && bit_tick === 1'b1) t++;
      if (++c > 400) give_up("idle_expired");
    end
  endtask
  task automatic wait_phase();
    int c;
    c = 0;
    @(negedge sys_clk);
    while (bit_tick !== 1'b1) begin
      if (++c > 20) give_up("bit_tick");
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {rx_read, clr, addr_cmd, wait_cmd, rearm_cmd, tx_write, rx_go, rx_par} = 8'h00;
    {tx_wdata, rx_word} = 18'h00000;
    kind = CHK_NONE;
    gap = GAP_ZERO;
    idle_lim = IDLE_ZERO;
    irq_en = 5'h00;
    fails = 0;
    comparisons = 0;
    seed = 32'h4773eeb3;
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("reset_flags", {avail, ovr, chk_err, tx_free, tx_idle, idle_exp, irq}, 16'h000c);
    check("reset_rhr", rhr, RHR_RESET);
    for (int i = 0; i < FLAG_W; i++) begin
      irq_en = 5'h01 << i;
      repeat (2) @(negedge sys_clk);
      check("irq_single", irq, i == FLG_TXFREE);
    end
    irq_en = 5'h01 << FLG_RXAVAIL;
    d = {1'b0, 8'($random(seed))};
    rx_char(d, 1'b0);
    check("rhr_first", rhr, d);
    check("avail", {avail, irq}, 16'h0003);
    rx_char(~d & 9'h0ff, 1'b0);
    check("rhr_over", rhr, ~d & 9'h0ff);
    check("overwrite", ovr, 1);
    pulse(4);
    check("read_clears", {avail, ovr}, 16'h0001);
    pulse(0);
    check("ovr_cleared", ovr, 0);
    irq_en = 5'h00;
    for (int k = 0; k < 8; k++) begin
      kind = k[2:0];
      d = k[0] ? {1'b0, 8'($random(seed))} : 9'h041;
      tx_send(d);
      check("tx_data", tx_data, d);
      check("tx_chk", {tx_chk_en, tx_chk_en & tx_chk}, {has_bit(kind), good_bit(kind, d)});
      tx_finish(1'b0, held);
      check("no_gap", 16'(held), 0);
      rx_char(d, ~good_bit(kind, d));
      check("chk_bad", chk_err, has_bit(kind));
      rx_char(d, good_bit(kind, d));
      check("chk_sticky", chk_err, has_bit(kind));
      pulse(0);
      check("chk_cleared", chk_err, 0);
      pulse(4);
    end
    kind = CHK_MULTI_A;
    pulse(1);
    tx_send(9'h0a5);
    check("addr_mark", {tx_chk_en, tx_chk}, 16'h0003);
    tx_finish(1'b0, held);
    tx_send(9'h05a);
    check("data_after_addr", {tx_chk_en, tx_chk}, 16'h0002);
    tx_finish(1'b0, held);
    for (int j = 0; j < 2; j++) begin
      g = j ? 255 : 1;
      gap = 8'(g);
      tx_send(9'h011);
      d = {1'b0, 8'($random(seed))};
      tx_put(d);
      check("free_after_fill", tx_free, 0);
      tx_put(~d & 9'h0ff);
      tx_finish(1'b1, held);
      check("gap_ticks", 16'(held), 16'(g));
      check("refused_write", tx_data, d);
      @(negedge sys_clk);
      check("free_at_start", tx_free, 1);
      tx_finish(1'b0, held);
      check("gap_ticks_last", {tx_idle, 8'(held)}, {1'b1, 8'(g)});
    end
    gap = GAP_ZERO;
    kind = CHK_NONE;
    rx_char(9'h033, 1'b0);
    repeat (200) @(negedge sys_clk);
    check("idle_off", idle_exp, 0);
    idle_lim = 16'h0006;
    rx_char(9'h034, 1'b0);
    ticks_to_expiry(n);
    check("idle_count", 16'(n), idle_lim);
    pulse(2);
    check("wait_clears", idle_exp, 0);
    // restart the count, then freeze it two cycles later so the wait has something to stop
    pulse(3);
    pulse(2);
    repeat (100) @(negedge sys_clk);
    check("wait_frozen", idle_exp, 0);
    rx_char(9'h035, 1'b0);
    ticks_to_expiry(n);
    check("idle_after_wait", 16'(n), idle_lim);
    irq_en = 5'h01 << FLG_IDLE;
    wait_phase();
    pulse(3);
    check("rearm_clears", {idle_exp, irq}, 16'h0000);
    ticks_to_expiry(n);
    check("rearm_count", 16'(n), idle_lim);
    @(negedge sys_clk);
    check("idle_irq", irq, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
